// >>> clock_reset_cfg.svh
// Constants for reset initialisation and system clock control
// Behaviour
// - PC loaded from three vector bytes
// - Stack pointer preset to 100H
// - Interrupt mask level set to 111
// - Addressing mode bit set to one
// - Register bank pointer cleared to zero
// - Fetch from PC; other core registers kept
// - Internal RAM untouched by reset
// - Peripheral control registers return to defaults
// - Port pins revert to plain ports
// - Address latch pin floats during reset
// - Single clock mode only; low clock not modelled, so dual mode stops system ticks
// - System clock divides selected source clock
// - Bits 7,6 enable high, low oscillators
// - Bits 5,4 oscillator run after stop
// - Bit 3 selects clock after stop
// - Bit 2 starts warmup, reads busy
// - Bit 1 selects prescaler source
// - Second register: source select, gear field
// - Gear codes divide by 1..16, rest reserved
// - Unused bits read undefined value
`ifndef CLOCK_RESET_CFG_SVH
`define CLOCK_RESET_CFG_SVH
`define OSC_CTRL_ADDR      8'he0
`define SRC_GEAR_ADDR      8'he1
`define OSC_CTRL_RESET     8'ha0
`define SRC_GEAR_RESET     4'h0
`define VEC_ADDR_LO        24'hffff00
`define VEC_ADDR_MID       24'hffff01
`define VEC_ADDR_HI        24'hffff02
`define STACK_RESET        32'h00000100
`define MASK_LEVEL_RESET   3'h7
`define BANK_RESET         3'h0
`define UNDEF_READ         1'b0
`define WARMUP_CYCLES      16'h0100
`define GEAR_MAX_CODE      3'h4
`define BIT_HIGH_RUN       7
`define BIT_LOW_RUN        6
`define BIT_HIGH_AFTER     5
`define BIT_LOW_AFTER      4
`define BIT_AFTER_SEL      3
`define BIT_WARMUP         2
`define BIT_PRESCALE       1
`define BIT_SRC_SEL        3
`endif

// >>> clock_reset_pkg.sv
// Types for reset initialisation and system clock control
package clock_reset_pkg;
	// Vector fetch sequence states, Gray along the path
	typedef enum logic [1:0] {
		VEC_LO  = 2'b00,
		VEC_MID = 2'b01,
		VEC_HI  = 2'b11,
		RUN     = 2'b10
	} boot_state_t;
endpackage

// >>> reset_init_and_clock_select.sv
// Reset-time core initialisation and system clock control registers
`timescale 1ns/1ps
`include "clock_reset_cfg.svh"
module reset_init_and_clock_select
	import clock_reset_pkg::*;
(
	input  wire logic        core_clk_in,      // 20 MHz core clock
	input  wire logic        rst_in,           // Synchronous reset, active high
	input  wire logic        reset_pin_n_in,   // External reset pin, active low
	input  wire logic [7:0]  reg_addr_in,      // Register address
	input  wire logic [7:0]  reg_wdata_in,     // Register write data
	input  wire logic        reg_wr_in,        // Write strobe
	input  wire logic        reg_rd_in,        // Read strobe
	output logic      [7:0]  reg_rdata_out,    // Read data, one cycle later
	output logic      [23:0] vec_addr_out,     // Vector byte address
	input  wire logic [7:0]  vec_data_in,      // Vector byte, same cycle
	output logic      [23:0] program_counter_out, // Loaded program counter
	output logic             fetch_enable_out, // Core may fetch
	output logic      [31:0] system_stack_pointer_out, // Preset stack pointer
	output logic      [2:0]  interrupt_mask_level_out, // Status mask field
	output logic             max_mode_out,     // Status addressing mode
	output logic      [2:0]  register_bank_pointer_out, // Status bank field
	output logic             core_init_out,    // High while reset stands: apply core presets
	output logic             periph_reset_out, // Peripheral registers to defaults
	output logic             port_mode_reset_out, // Ports forced to plain ports
	output logic             ale_oe_out,       // Address latch pin drive enable
	output logic             high_osc_run_out, // High oscillator enable
	output logic             low_osc_run_out,  // Low oscillator enable
	output logic             high_osc_run_after_stop_out, // High osc after stop
	output logic             low_osc_run_after_stop_out,  // Low osc after stop
	output logic             clock_after_stop_select_out, // 0 high, 1 low
	output logic             prescaler_source_select_out, // 0 source, 1 high/16
	output logic             clock_source_select_out,     // 0 high, 1 low
	output logic             system_clock_en_out,   // One pulse per state
	output logic             prescaler_clock_en_out // Prescaler tick
);

////////////////////////////////////////////////////////////////////////////////
// Reset pin synchroniser and combined reset

	logic       pin_meta_reg;   // First stage, read only by second
	logic       pin_sync_reg;   // Second stage
	logic       in_reset;       // Any reset active

	// Two flops before the pin is looked at
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pin_meta_reg <= 1'b1;
			pin_sync_reg <= 1'b1;
		end else begin
			pin_meta_reg <= reset_pin_n_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Either source resets everything below except that the pin leaves the program counter; the pin is seen two edges late
	// Trade-off: the pin path costs two cycles but never feeds raw metastability
	assign in_reset = rst_in | ~pin_sync_reg;

////////////////////////////////////////////////////////////////////////////////
// Vector fetch and core presets

	boot_state_t boot_reg;      // Fetch sequence state
	boot_state_t boot_next;     // Next fetch state

	// Walk the three vector bytes after release
	// One byte per cycle; the memory must answer in the same cycle
	always_comb begin
		case (boot_reg)
			VEC_LO:  boot_next = VEC_MID;
			VEC_MID: boot_next = VEC_HI;
			VEC_HI:  boot_next = RUN;
			RUN:     boot_next = RUN;
			default: boot_next = VEC_LO;
		endcase
	end

	// State holds at the first byte while reset stands
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			boot_reg <= VEC_LO;
		else
			boot_reg <= boot_next;
	end

	// Outside the walk the address rests on the first byte
	// Vector address follows the next state so data is ready in time
	always_ff @(posedge core_clk_in) begin
		if (in_reset) begin
			vec_addr_out <= `VEC_ADDR_LO;
		end else begin
			case (boot_next)
				VEC_MID: vec_addr_out <= `VEC_ADDR_MID;
				VEC_HI:  vec_addr_out <= `VEC_ADDR_HI;
				default: vec_addr_out <= `VEC_ADDR_LO;
			endcase
		end
	end

	// Capture vector bytes into the program counter
	// The pin reset leaves the counter alone; only a core reset clears it
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			program_counter_out <= 24'h000000;
		end else if (!in_reset) begin
			case (boot_reg)
				VEC_LO:  program_counter_out[7:0]   <= vec_data_in;
				VEC_MID: program_counter_out[15:8]  <= vec_data_in;
				VEC_HI:  program_counter_out[23:16] <= vec_data_in;
				default: program_counter_out        <= program_counter_out;
			endcase
		end
	end

	// Fetching starts only once the whole vector is in
	// Level stays high until the next reset of either kind
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			fetch_enable_out <= 1'b0;
		else
			fetch_enable_out <= (boot_next == RUN);
	end

	// Core status presets; other core state is not ours to touch
	// No else branch: values hold until the core loads its own
	always_ff @(posedge core_clk_in) begin
		if (in_reset) begin
			system_stack_pointer_out  <= `STACK_RESET;
			interrupt_mask_level_out  <= `MASK_LEVEL_RESET;
			max_mode_out              <= 1'b1;
			register_bank_pointer_out <= `BANK_RESET;
		end
	end

	// Presets apply while reset stands; RAM has no reset path
	always_ff @(posedge core_clk_in) begin
		core_init_out <= in_reset;
	end

	// Peripheral defaults, ports and address latch float during reset
	always_ff @(posedge core_clk_in) begin
		periph_reset_out    <= in_reset;
		port_mode_reset_out <= in_reset;
		ale_oe_out          <= ~in_reset;
	end

////////////////////////////////////////////////////////////////////////////////
// Clock control registers

	logic [7:0]  osc_ctrl_reg;  // Oscillator and warmup control, bit 2 unused
	logic [3:0]  src_gear_reg;  // Source select and gear divider
	logic [15:0] warmup_cnt_reg; // Warmup countdown
	logic        warmup_busy;   // Warmup in progress
	logic        wr_osc;        // Write to first register
	logic        wr_gear;       // Write to second register

	assign wr_osc  = reg_wr_in && (reg_addr_in == `OSC_CTRL_ADDR);
	assign wr_gear = reg_wr_in && (reg_addr_in == `SRC_GEAR_ADDR);
	assign warmup_busy = (warmup_cnt_reg != 16'h0000);

	// First register; reset puts defaults back
	// Bit 2 is never stored; its read comes from the warm-up count
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			osc_ctrl_reg <= `OSC_CTRL_RESET;
		else if (wr_osc)
			osc_ctrl_reg <= {reg_wdata_in[7:3], 1'b0, reg_wdata_in[1], 1'b0};
	end

	// Second register
	// Upper four bits are dropped, they read undefined
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			src_gear_reg <= `SRC_GEAR_RESET;
		else if (wr_gear)
			src_gear_reg <= reg_wdata_in[3:0];
	end

	// Writing one restarts warmup, zero ignored; countdown reads busy
	// Limitation: one fixed length, no selectable warm-up time here
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			warmup_cnt_reg <= 16'h0000;
		else if (wr_osc && reg_wdata_in[`BIT_WARMUP])
			warmup_cnt_reg <= `WARMUP_CYCLES;
		else if (warmup_busy)
			warmup_cnt_reg <= warmup_cnt_reg - 16'h0001;
	end

	// Read mux; undefined bits read as zero here
	// Data stand one cycle only, so an idle cycle returns zero
	always_ff @(posedge core_clk_in) begin
		if (in_reset) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`OSC_CTRL_ADDR: reg_rdata_out <= {osc_ctrl_reg[7:3], warmup_busy,
					osc_ctrl_reg[1], `UNDEF_READ};
				`SRC_GEAR_ADDR: reg_rdata_out <= {4'h0, src_gear_reg};
				default:        reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// Register fields out to the oscillators
	// One cycle of lag is the price of driving outputs from flops
	always_ff @(posedge core_clk_in) begin
		high_osc_run_out            <= osc_ctrl_reg[`BIT_HIGH_RUN];
		low_osc_run_out             <= osc_ctrl_reg[`BIT_LOW_RUN];
		high_osc_run_after_stop_out <= osc_ctrl_reg[`BIT_HIGH_AFTER];
		low_osc_run_after_stop_out  <= osc_ctrl_reg[`BIT_LOW_AFTER];
		clock_after_stop_select_out <= osc_ctrl_reg[`BIT_AFTER_SEL];
		prescaler_source_select_out <= osc_ctrl_reg[`BIT_PRESCALE];
		clock_source_select_out     <= src_gear_reg[`BIT_SRC_SEL];
	end

////////////////////////////////////////////////////////////////////////////////
// Clock dividers as enables; core clock stands for the high clock

	logic [3:0] div_cnt_reg;    // Free running divider
	logic       gear_tick;      // Gear-divided tick
	logic       src_tick;       // Selected source tick
	logic       low_tick_sync;  // Low clock tick, not modelled here

	// Gear code to divider tick; reserved codes fall back to divide by 1
	function automatic logic gear_hit(input logic [2:0] code, input logic [3:0] cnt);
		case (code)
			3'h0:    gear_hit = 1'b1;
			3'h1:    gear_hit = (cnt[0] == 1'b1);
			3'h2:    gear_hit = (cnt[1:0] == 2'h3);
			3'h3:    gear_hit = (cnt[2:0] == 3'h7);
			3'h4:    gear_hit = (cnt == 4'hf);
			default: gear_hit = 1'b1;
		endcase
	endfunction

	// Free divider runs from release; every gear shares its phase
	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			div_cnt_reg <= 4'h0;
		else
			div_cnt_reg <= div_cnt_reg + 4'h1;
	end

	// Limitation: the low clock is absent, so selecting it stops system ticks and source-fed prescaler ticks
	assign gear_tick     = gear_hit(src_gear_reg[2:0], div_cnt_reg);
	assign low_tick_sync = 1'b0;
	assign src_tick      = src_gear_reg[`BIT_SRC_SEL] ? low_tick_sync : gear_tick;

	// System clock is half the selected clock, each pulse one state
	logic half_reg;             // Divide-by-two toggle

	always_ff @(posedge core_clk_in) begin
		if (in_reset)
			half_reg <= 1'b0;
		else if (src_tick)
			half_reg <= ~half_reg;
	end

	// Output enables; prescaler at high/16 reuses the free divider
	always_ff @(posedge core_clk_in) begin
		if (in_reset) begin
			system_clock_en_out    <= 1'b0;
			prescaler_clock_en_out <= 1'b0;
		end else begin
			system_clock_en_out    <= src_tick & half_reg;
			prescaler_clock_en_out <= osc_ctrl_reg[`BIT_PRESCALE] ?
				(div_cnt_reg == 4'hf) : src_tick;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Assertions

	// Start of a warm-up request
	sequence warm_start_s;
		wr_osc && reg_wdata_in[`BIT_WARMUP];
	endsequence

	// Vector address steps through the three bytes after release
	sequence vec_addr_s;
		vec_addr_out == `VEC_ADDR_LO ##1 vec_addr_out == `VEC_ADDR_MID
			##1 vec_addr_out == `VEC_ADDR_HI;
	endsequence

	// Fetch state takes the same three steps
	sequence vec_state_s;
		boot_reg == VEC_LO ##1 boot_reg == VEC_MID ##1 boot_reg == VEC_HI;
	endsequence

	// Flag reads busy well past the start write
	warmup_flag_busy_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		warm_start_s |=> warmup_busy[*8])
		else $error("warmup flag not busy after start");
	// Flag clears once the last count is gone
	warmup_end_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		warmup_cnt_reg == 16'h0001 && !(wr_osc && reg_wdata_in[`BIT_WARMUP])
			|=> !warmup_busy)
		else $error("warmup flag still busy at end");
	// A read of the first register carries the live flag
	warm_read_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		reg_rd_in && reg_addr_in == `OSC_CTRL_ADDR
			|=> reg_rdata_out[`BIT_WARMUP] == $past(warmup_busy))
		else $error("warmup flag not read back");

	// Stack pointer preset
	stack_preset_a: assert property (@(posedge core_clk_in)
		in_reset |=> system_stack_pointer_out == `STACK_RESET)
		else $error("stack pointer not preset");
	// Interrupt mask preset
	mask_level_a: assert property (@(posedge core_clk_in)
		in_reset |=> interrupt_mask_level_out == 3'h7 && max_mode_out)
		else $error("mask level or mode wrong");
	// Addressing mode preset
	max_mode_a: assert property (@(posedge core_clk_in)
		in_reset |=> max_mode_out)
		else $error("max mode not set");
	// Bank pointer preset
	bank_clear_a: assert property (@(posedge core_clk_in)
		in_reset |=> register_bank_pointer_out == 3'h0)
		else $error("bank pointer not cleared");
	// Peripheral defaults and core presets requested
	periph_default_a: assert property (@(posedge core_clk_in)
		in_reset |=> periph_reset_out && core_init_out)
		else $error("peripheral reset not requested");
	// Ports forced back to plain port use
	port_mode_a: assert property (@(posedge core_clk_in)
		in_reset |=> port_mode_reset_out)
		else $error("ports not forced to plain use");
	// Address latch pin floats
	ale_float_a: assert property (@(posedge core_clk_in)
		in_reset |=> !ale_oe_out && port_mode_reset_out)
		else $error("address latch driven in reset");

	// High vector byte lands in the top of the counter
	vector_load_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		boot_reg == VEC_HI |=> program_counter_out[23:16] == $past(vec_data_in))
		else $error("vector high byte not loaded");
	// Address walk, then fetch one cycle after the high byte
	vector_addr_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		$fell(in_reset) |-> vec_addr_s ##1 fetch_enable_out)
		else $error("vector address walk wrong");
	// State walk through the three bytes
	vector_walk_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		$fell(in_reset) |-> vec_state_s)
		else $error("vector state walk wrong");
	// Fetch window from release
	fetch_start_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		$fell(in_reset) |-> ##[3:4] fetch_enable_out)
		else $error("fetch did not start");

	// Oscillator control back at defaults
	osc_default_a: assert property (@(posedge core_clk_in)
		in_reset |=> osc_ctrl_reg == `OSC_CTRL_RESET)
		else $error("oscillator control not at default");
	// Gear register takes the written value
	gear_write_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		wr_gear |=> src_gear_reg == $past(reg_wdata_in[3:0]))
		else $error("gear register not written");
	// Upper bits of the second register read the undefined value
	undef_read_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		reg_rd_in && reg_addr_in == `SRC_GEAR_ADDR |=> reg_rdata_out[7:4] == {4{`UNDEF_READ}})
		else $error("undefined bits not as chosen");

	// States never come back to back
	sys_gap_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		system_clock_en_out |=> !system_clock_en_out)
		else $error("system ticks back to back");
	// Divide by sixteen pulses only at counter wrap
	sys_gear_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		system_clock_en_out && $past(src_gear_reg) == 4'h4 |-> $past(div_cnt_reg) == 4'hf)
		else $error("gear sixteen tick out of phase");
	// Prescaler at high/16 fires on counter wrap
	prescale_hi_a: assert property (@(posedge core_clk_in) disable iff (in_reset)
		osc_ctrl_reg[`BIT_PRESCALE] && div_cnt_reg == 4'hf |=> prescaler_clock_en_out)
		else $error("prescaler tick missing");

endmodule

// >>> tb_reset_init_and_clock_select.sv
// Self-checking bench for reset initialisation and clock control
`timescale 1ns/1ps
`include "clock_reset_cfg.svh"
module tb_reset_init_and_clock_select;
	logic        core_clk_in = 1'b0;     // 50 ns clock
	logic        rst_in = 1'b1;          // Sync reset, held from time zero
	logic        reset_pin_n_in = 1'b1;  // External reset pin
	logic [7:0]  reg_addr_in = 8'h00;    // Bus address
	logic [7:0]  reg_wdata_in = 8'h00;   // Bus write data
	logic        reg_wr_in = 1'b0;       // Write strobe
	logic        reg_rd_in = 1'b0;       // Read strobe
	logic [7:0]  reg_rdata_out, vec_data_in;
	logic [23:0] vec_addr_out, program_counter_out;
	logic [31:0] system_stack_pointer_out;
	logic [2:0]  interrupt_mask_level_out, register_bank_pointer_out;
	logic        fetch_enable_out, max_mode_out, core_init_out, periph_reset_out;
	logic        port_mode_reset_out, ale_oe_out, high_osc_run_out, low_osc_run_out;
	logic        high_osc_run_after_stop_out, low_osc_run_after_stop_out;
	logic        clock_after_stop_select_out, prescaler_source_select_out;
	logic        clock_source_select_out, system_clock_en_out, prescaler_clock_en_out;
	logic [7:0]  vec_mem [4];            // Vector bytes, index = low address bits
	logic [31:0] lfsr_reg = 32'ha562;    // Fixed seed keeps runs repeatable
	int          n_errors = 0;           // Mismatch count
	int          checks_done = 0;        // Comparison count

	////////////////////////////////////////////////////////////////////////////////
	// Clock, vector memory and design
	always #25 core_clk_in = ~core_clk_in;
	// Memory answers in the same cycle; off-vector addresses give a junk byte
	assign vec_data_in = (vec_addr_out[23:2] == 22'h3fffc0) ? vec_mem[vec_addr_out[1:0]] : 8'h3c;

	reset_init_and_clock_select reset_init_and_clock_select_inst (
		.core_clk_in, .rst_in, .reset_pin_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .vec_addr_out, .vec_data_in, .program_counter_out,
		.fetch_enable_out, .system_stack_pointer_out, .interrupt_mask_level_out,
		.max_mode_out, .register_bank_pointer_out, .core_init_out, .periph_reset_out,
		.port_mode_reset_out, .ale_oe_out, .high_osc_run_out, .low_osc_run_out,
		.high_osc_run_after_stop_out, .low_osc_run_after_stop_out,
		.clock_after_stop_select_out, .prescaler_source_select_out,
		.clock_source_select_out, .system_clock_en_out, .prescaler_clock_en_out
	);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	// Eight Galois steps per byte so successive bytes are not shifted copies
	function automatic logic [7:0] rand_byte();
		for (int i = 0; i < 8; i++) begin
			lfsr_reg = {1'b0, lfsr_reg[31:1]} ^ (lfsr_reg[0] ? 32'h80200003 : 32'h0);
		end
		return lfsr_reg[7:0];
	endfunction
	// Gear divider; reserved codes run undivided
	function automatic int gear_div(input int g);
		return (g <= 4) ? (1 << g) : 1;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	// 64 cycles: every expected period divides it, so phase does not matter
	task automatic count_ticks(output int sys_n, output int pre_n);
		sys_n = 0;
		pre_n = 0;
		repeat (8) @(posedge core_clk_in);
		repeat (64) begin
			@(posedge core_clk_in);
			#1;
			if (system_clock_en_out === 1'b1) sys_n++;
			if (prescaler_clock_en_out === 1'b1) pre_n++;
		end
	endtask
	// Reset by either source with a fresh vector, then check the boot presets
	task automatic boot(input bit use_pin, input int hold);
		logic [7:0] d;
		int n;
		for (int i = 0; i < 3; i++) vec_mem[i] = rand_byte();
		@(posedge core_clk_in);
		if (use_pin) reset_pin_n_in <= 1'b0;
		else rst_in <= 1'b1;
		repeat (hold) @(posedge core_clk_in);
		#1;
		chk(ale_oe_out, 1'b0);
		chk({core_init_out, periph_reset_out, port_mode_reset_out}, 3'b111);
		chk(fetch_enable_out, 1'b0);
		@(posedge core_clk_in);
		rst_in <= 1'b0;
		reset_pin_n_in <= 1'b1;
		n = 0;
		while (fetch_enable_out !== 1'b1 && n < 20) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		chk(fetch_enable_out, 1'b1);
		// Core reset needs three byte cycles; the pin adds its two sync edges
		chk(n, use_pin ? 5 : 3);
		chk(program_counter_out, {vec_mem[2], vec_mem[1], vec_mem[0]});
		chk(system_stack_pointer_out, 32'h100);
		chk(interrupt_mask_level_out, 3'h7);
		chk(max_mode_out, 1'b1);
		chk(register_bank_pointer_out, 3'h0);
		chk({core_init_out, periph_reset_out, port_mode_reset_out, ale_oe_out}, 4'b0001);
		rd(`OSC_CTRL_ADDR, d);
		chk(d, 8'ha0);
		rd(`SRC_GEAR_ADDR, d);
		chk(d, 8'h00);
		chk({high_osc_run_out, low_osc_run_out, high_osc_run_after_stop_out,
			low_osc_run_after_stop_out, clock_after_stop_select_out,
			prescaler_source_select_out, clock_source_select_out}, 7'b1010000);
		$display("test boot done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Closing and watchdog
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Tests need about 1350 cycles; some fifteen times that means a hang
	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d, w;
		int s, p;
		vec_mem[3] = 8'h00;
		boot(1'b0, 8);
		// Random traffic; warm-up bit kept clear here, an unmapped place among it
		repeat (20) begin
			w = rand_byte() & 8'hfb;
			wr(`OSC_CTRL_ADDR, w);
			rd(`OSC_CTRL_ADDR, d);
			chk(d, {w[7:3], 1'b0, w[1], 1'b0});
			chk({high_osc_run_out, low_osc_run_out, high_osc_run_after_stop_out,
				low_osc_run_after_stop_out, clock_after_stop_select_out,
				prescaler_source_select_out}, {w[7:3], w[1]});
			w = rand_byte();
			wr(`SRC_GEAR_ADDR, w);
			rd(`SRC_GEAR_ADDR, d);
			chk(d, {4'h0, w[3:0]});
			chk(clock_source_select_out, w[3]);
			wr(8'he7, ~w);
			rd(8'he7, d);
			chk(d, 8'h00);
			rd(`SRC_GEAR_ADDR, d);
			chk(d, {4'h0, w[3:0]});
		end
		// The block never moves the stack pointer; software must load its own
		chk(system_stack_pointer_out, 32'h100);
		$display("test register traffic done");
		// Warm-up: start, a zero write that must not stop it, then expiry
		wr(`OSC_CTRL_ADDR, 8'ha4);
		wr(`OSC_CTRL_ADDR, 8'ha0);
		rd(`OSC_CTRL_ADDR, d);
		chk(d, 8'ha4);
		repeat (230) @(posedge core_clk_in);
		rd(`OSC_CTRL_ADDR, d);
		chk(d, 8'ha4);
		repeat (40) @(posedge core_clk_in);
		rd(`OSC_CTRL_ADDR, d);
		chk(d, 8'ha0);
		$display("test warmup done");
		// Every gear code, system ticks at half the geared rate
		for (int g = 0; g < 8; g++) begin
			wr(`SRC_GEAR_ADDR, g[7:0]);
			count_ticks(s, p);
			chk(32'(s), 32'(64 / (2 * gear_div(g))));
			chk(32'(p), 32'(64 / gear_div(g)));
		end
		wr(`OSC_CTRL_ADDR, 8'ha2);
		count_ticks(s, p);
		chk(32'(p), 32'd4);
		wr(`SRC_GEAR_ADDR, 8'h08);
		count_ticks(s, p);
		chk(32'(s), 32'd0);
		$display("test clock gear done");
		// Second reset from the pin with non-default settings in place
		wr(`OSC_CTRL_ADDR, 8'h5a);
		boot(1'b1, 12);
		wrap_up();
	end
endmodule
